/* hw/tcep_top.sv */
// Channel enable/polarity control and counter register behind an AHB-Lite slave.
// Assumes a single 100 MHz clock, synchronous inputs and word-only transfers.
`timescale 1ns/1ps
`include "tcep_defines.svh"

module tcep_top (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst,
   input  wire logic        i_clk_en,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   input  wire logic [3:0]  i_oc_ref,
   input  wire logic [3:0]  i_ti_filt,
   input  wire logic        i_commutation,
   input  wire logic        i_count_tick,
   output logic             o_hreadyout,
   output logic             o_hresp,
   output logic [31:0]      o_hrdata,
   output logic [3:0]       o_main_out,
   output logic [2:0]       o_comp_out,
   output logic [3:0]       o_capture_en,
   output logic [3:0]       o_capture_strobe,
   output logic [3:0]       o_ti_pol,
   output logic [15:0]      o_counter_value
);

   // ============================================================
   // State
   tcep_pkg::tcep_state_t s;
   tcep_pkg::tcep_state_t next_s;

   logic [3:0] w_main;
   logic [3:0] w_comp;
   logic [3:0] w_cap_en;
   logic [3:0] w_strobe;
   logic [3:0] w_ti_pol;

   logic       w_preload;
   logic       w_locked;
   logic       w_wr;
   logic [3:0] w_is_in;

   assign w_preload = s.ctrl[`TCEP_CTRL_PRE];
   assign w_locked  = (s.ctrl[`TCEP_CTRL_LOCK +: 2] >= `TCEP_LOCK_MIN);
   assign w_wr      = s.dp.sel & s.dp.write;
   assign w_is_in   = s.ctrl[`TCEP_CTRL_IN +: 4];

   // ============================================================
   // Per-channel output and input path
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_chan
         logic                 en;
         logic                 pol;
         logic                 cen;
         logic                 cpol;
         tcep_pkg::tcep_edge_t code;
         logic                 ti_p;
         assign en   = s.chen[gi*`TCEP_CH_STRIDE + `TCEP_BIT_EN];
         assign pol  = s.chen[gi*`TCEP_CH_STRIDE + `TCEP_BIT_POL];
         assign cen  = s.chen[gi*`TCEP_CH_STRIDE + `TCEP_BIT_CEN];
         assign cpol = s.chen[gi*`TCEP_CH_STRIDE + `TCEP_BIT_CPOL];
         assign code = tcep_pkg::tcep_edge_t'({cpol, pol});
         // Main output gated by enable, inverted by polarity
         assign w_main[gi] = en & ~w_is_in[gi] & (i_oc_ref[gi] ^ pol);
         // Complementary output from inverted reference
         assign w_comp[gi] = cen & ~w_is_in[gi] & (~i_oc_ref[gi] ^ cpol);
         assign w_cap_en[gi] = en & w_is_in[gi];
         // Inversion only for the falling-edge code
         assign ti_p = i_ti_filt[gi] ^ (code == tcep_pkg::TCEP_EDGE_FALL);
         assign w_ti_pol[gi] = ti_p;
         // Both edges on code 11, rising edge of adjusted input otherwise
         assign w_strobe[gi] = w_cap_en[gi] &
            ((code == tcep_pkg::TCEP_EDGE_BOTH) ? (ti_p ^ s.ti_pol[gi])
                                                : (ti_p & ~s.ti_pol[gi]));
      end
   endgenerate

   // ============================================================
   // Next state
   always_comb begin
      logic [15:0] wval;
      logic [15:0] rd_chen;
      logic        addr_ok;
      wval    = i_hwdata[15:0] & `TCEP_CHEN_MASK;
      rd_chen = 16'h0000;
      addr_ok = 1'b0;
      next_s  = s;

      // Counter runs on ticks; a software write wins
      if (i_count_tick) begin
         next_s.cnt = s.cnt + 16'h0001;
      end
      if (w_wr && s.dp.addr == `TCEP_OFS_CNT) begin
         next_s.cnt = i_hwdata[15:0];
      end

      if (w_wr && s.dp.addr == `TCEP_OFS_CTRL) begin
         next_s.ctrl = i_hwdata[7:0] & `TCEP_CTRL_MASK;
      end

      if (w_wr && s.dp.addr == `TCEP_OFS_CHEN) begin
         // Enables and main polarities take effect at once
         next_s.chen = (wval & ~`TCEP_CPOL_MASK) | (s.chen & `TCEP_CPOL_MASK);
         if (!w_locked) begin
            next_s.cpol_shadow = {wval[11], wval[7], wval[3]};
         end
         if (!w_preload) begin
            for (int k = 0; k < 3; k++) begin
               next_s.chen[k*`TCEP_CH_STRIDE + `TCEP_BIT_CPOL] = next_s.cpol_shadow[k];
            end
         end
      end

      // Commutation loads preloaded complementary polarities
      if (w_preload && i_commutation) begin
         for (int k = 0; k < 3; k++) begin
            next_s.chen[k*`TCEP_CH_STRIDE + `TCEP_BIT_CPOL] = next_s.cpol_shadow[k];
         end
      end

      // Address phase capture
      next_s.dp.sel   = i_hsel & i_htrans[1] & i_hready;
      next_s.dp.write = i_hwrite;
      next_s.dp.addr  = i_haddr[7:0];

      // Read data from post-write values, shadow shown for comp polarity
      rd_chen = next_s.chen & `TCEP_CHEN_MASK;
      for (int k = 0; k < 3; k++) begin
         rd_chen[k*`TCEP_CH_STRIDE + `TCEP_BIT_CPOL] = next_s.cpol_shadow[k];
      end
      next_s.rdata = 32'h0000_0000;
      addr_ok      = i_hsel & i_htrans[1] & i_hready & ~i_hwrite;
      if (addr_ok) begin
         case (i_haddr[7:0])
            `TCEP_OFS_CHEN: next_s.rdata = {16'h0000, rd_chen};
            `TCEP_OFS_CNT:  next_s.rdata = {16'h0000, next_s.cnt};
            `TCEP_OFS_CTRL: next_s.rdata = {24'h00_0000, next_s.ctrl};
            default:        next_s.rdata = 32'h0000_0000;
         endcase
      end
      next_s.ready = 1'b1;

      // Registered pin side
      next_s.main_out   = w_main;
      next_s.comp_out   = w_comp[2:0];
      next_s.cap_en     = w_cap_en;
      next_s.cap_strobe = w_strobe;
      next_s.ti_pol     = w_ti_pol;
   end

   // ============================================================
   // Registers
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         s             <= '0;
         s.chen        <= `TCEP_CHEN_RST;
         s.cnt         <= `TCEP_CNT_RST;
         s.ctrl        <= `TCEP_CTRL_RST;
         s.ready       <= 1'b1;
      end else if (i_clk_en) begin
         s <= next_s;
      end
   end

   assign o_hreadyout      = s.ready;
   assign o_hresp          = 1'b0;
   assign o_hrdata         = s.rdata;
   assign o_main_out       = s.main_out;
   assign o_comp_out       = s.comp_out;
   assign o_capture_en     = s.cap_en;
   assign o_capture_strobe = s.cap_strobe;
   assign o_ti_pol         = s.ti_pol;
   assign o_counter_value  = s.cnt;

   // ============================================================
   // Assertions
   sequence s_cnt_write;
      i_clk_en && w_wr && s.dp.addr == `TCEP_OFS_CNT;
   endsequence

   sequence s_chen_write_locked;
      i_clk_en && w_wr && s.dp.addr == `TCEP_OFS_CHEN && w_locked;
   endsequence

   a_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      s.chen[15:14] == 2'h0 && o_hrdata[31:16] == 16'h0000)
      else $error("reserved enable bits not zero");

   a_counter_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      s_cnt_write |=> o_counter_value == $past(i_hwdata[15:0]))
      else $error("counter write not stored");

   a_lock_ignore: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      s_chen_write_locked |=> $stable(s.cpol_shadow))
      else $error("locked comp polarity changed");

   a_preload_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_clk_en && w_preload && !i_commutation
      |=> {s.chen[11], s.chen[7], s.chen[3]} == $past({s.chen[11], s.chen[7], s.chen[3]}))
      else $error("active comp polarity changed without commutation");

   a_commute_load: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_clk_en && w_preload && i_commutation && !w_wr
      |=> {s.chen[11], s.chen[7], s.chen[3]} == s.cpol_shadow)
      else $error("commutation did not load comp polarity");

   a_main_drive: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_clk_en ##1 i_clk_en
      |-> ##1 o_main_out[0] == $past(s.chen[0] & ~w_is_in[0] & (i_oc_ref[0] ^ s.chen[1])))
      else $error("channel 1 main output wrong");

   a_comp_drive: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_clk_en && !w_is_in[2]
      |=> o_comp_out[2] == $past(s.chen[10] & (~i_oc_ref[2] ^ s.chen[11])))
      else $error("channel 3 comp output wrong");

   a_ch2_mirror: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_clk_en && !s.chen[4] |=> !o_main_out[1] && !o_capture_en[1])
      else $error("channel 2 active while disabled");

   a_capture_block: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_clk_en && !(s.chen[0] && w_is_in[0]) |=> !o_capture_strobe[0])
      else $error("capture while disabled");

   a_both_edges: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_clk_en && w_is_in[1] && s.chen[4] && s.chen[5] && s.chen[7]
      && (i_ti_filt[1] != s.ti_pol[1])
      |=> o_capture_strobe[1])
      else $error("both-edge capture missed");

   a_fall_invert: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_clk_en && s.chen[1] && !s.chen[3]
      |=> o_ti_pol[0] == !$past(i_ti_filt[0]))
      else $error("falling code not inverted");

   // ============================================================
   // Bus, counter and clock enable assertions
   sequence s_read_addr;
      i_clk_en && i_hsel && i_htrans[1] && i_hready && !i_hwrite;
   endsequence

   sequence s_tick_only;
      i_clk_en && i_count_tick && !(w_wr && s.dp.addr == `TCEP_OFS_CNT);
   endsequence

   sequence s_ctrl_write;
      i_clk_en && w_wr && s.dp.addr == `TCEP_OFS_CTRL;
   endsequence

   a_bus_okay: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_hresp == 1'b0 && o_hreadyout == 1'b1)
      else $error("bus response not okay and ready");

   a_cnt_readback: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      s_read_addr ##0 i_haddr[7:0] == `TCEP_OFS_CNT
      |=> o_hrdata == {16'h0000, o_counter_value})
      else $error("counter read data wrong");

   a_cnt_tick: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      s_tick_only |=> o_counter_value == $past(o_counter_value) + 16'h0001)
      else $error("counter did not step on tick");

   a_cnt_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_clk_en && !i_count_tick && !(w_wr && s.dp.addr == `TCEP_OFS_CNT)
      |=> $stable(o_counter_value))
      else $error("counter moved without tick or write");

   a_freeze_all: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !i_clk_en |=> $stable(s))
      else $error("state changed while clock enable low");

   a_rdata_idle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_clk_en && !(i_hsel && i_htrans[1] && i_hready && !i_hwrite)
      |=> o_hrdata == 32'h0000_0000)
      else $error("read data outside a read data phase");

   a_ctrl_resv: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      s_ctrl_write |=> s.ctrl[3] == 1'b0)
      else $error("reserved control bit stored");

   a_chen_resv_rd: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      s_read_addr ##0 i_haddr[7:0] == `TCEP_OFS_CHEN |=> o_hrdata[15:14] == 2'h0)
      else $error("reserved enable bits read non-zero");

   // ============================================================
   // Channel enable and polarity assertions
   sequence s_chen_write_open;
      i_clk_en && w_wr && s.dp.addr == `TCEP_OFS_CHEN && !w_locked;
   endsequence

   sequence s_ch1_capture;
      i_clk_en && w_is_in[0] && s.chen[0];
   endsequence

   a_shadow_load: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      s_chen_write_open |=> s.cpol_shadow == $past({i_hwdata[11], i_hwdata[7], i_hwdata[3]}))
      else $error("unlocked comp polarity write lost");

   a_direct_cpol: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      s_chen_write_open ##0 !w_preload
      |=> {s.chen[11], s.chen[7], s.chen[3]} == s.cpol_shadow)
      else $error("comp polarity not applied without preload");

   a_ch4_disable: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_clk_en && !s.chen[12] |=> !o_main_out[3] && !o_capture_en[3])
      else $error("channel 4 active while disabled");

   a_ch3_disable: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_clk_en && !s.chen[8] |=> !o_main_out[2] && !o_capture_en[2])
      else $error("channel 3 active while disabled");

   a_comp_off: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_clk_en && !s.chen[2] |=> !o_comp_out[0])
      else $error("channel 1 comp output while disabled");

   a_ch2_comp_off: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_clk_en && !s.chen[6] |=> !o_comp_out[1])
      else $error("channel 2 comp output while disabled");

   a_input_quiet: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_clk_en && w_is_in[0] |=> !o_main_out[0] && !o_comp_out[0])
      else $error("input channel drives outputs");

   a_cap_enable: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      s_ch1_capture |=> o_capture_en[0])
      else $error("capture not enabled");

   a_rise_strobe: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      s_ch1_capture ##0 !s.chen[1] && !s.chen[3] && i_ti_filt[0] && !s.ti_pol[0]
      |=> o_capture_strobe[0])
      else $error("rising edge capture missed");

   a_fall_strobe: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      s_ch1_capture ##0 s.chen[1] && !s.chen[3] && !i_ti_filt[0] && !s.ti_pol[0]
      |=> o_capture_strobe[0])
      else $error("falling edge capture missed");

   a_no_fall_strobe: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      s_ch1_capture ##0 !s.chen[1] && !s.chen[3] && !i_ti_filt[0] |=> !o_capture_strobe[0])
      else $error("capture on low input with rising code");

   a_tipol_plain: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_clk_en && !(s.chen[1] && !s.chen[3]) |=> o_ti_pol[0] == $past(i_ti_filt[0]))
      else $error("input inverted without falling code");

   a_ch4_invert: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_clk_en && s.chen[13] |=> o_ti_pol[3] == !$past(i_ti_filt[3]))
      else $error("channel 4 falling code not inverted");

endmodule

/* hw/tcep_defines.svh */
// Offsets, field positions, reset values and masks of the channel enable block.
// Assumes inclusion by bare name from the package and the top module.
//
// Functional notes
// - Channel enable bit 0 drives the main output, or allows capture on an input channel.
// - Polarity bit 1 makes an output channel's main output active low when set.
// - On an input channel the two polarity bits form an edge code: 00 rise, 01 fall, 11 both.
// - Complementary enable bit 2 turns the complementary output on when set.
// - Complementary polarity bit 3 makes the complementary output active low when set.
// - On an input channel the filtered trigger input is inverted only for the falling edge code 01.
// - With preload on, the active complementary polarity loads only on a commutation event.
// - At lock level 2 or 3 writes to the complementary polarity bits are ignored.
// - Channel 2 uses bits 4 to 7 with the same meaning as channel 1.
// - Channel 3 uses bits 8 to 11 with the same meaning as channel 1.
// - Channel 4 has only enable bit 12 and polarity bit 13; bits 15 to 14 are reserved.
// - The counter is a 16-bit read/write register at offset 0x24, zero after reset.
`ifndef TCEP_DEFINES_SVH
`define TCEP_DEFINES_SVH

// ============================================================
// Register offsets
`define TCEP_OFS_CHEN    8'h20
`define TCEP_OFS_CNT     8'h24
`define TCEP_OFS_CTRL    8'h48

// ============================================================
// Reset values and masks
`define TCEP_CHEN_RST    16'h0000
`define TCEP_CNT_RST     16'h0000
`define TCEP_CTRL_RST    8'h00
`define TCEP_CHEN_MASK   16'h3FFF
`define TCEP_CPOL_MASK   16'h0888
`define TCEP_CTRL_MASK   8'hF7

// ============================================================
// Field positions
`define TCEP_BIT_EN      0
`define TCEP_BIT_POL     1
`define TCEP_BIT_CEN     2
`define TCEP_BIT_CPOL    3
`define TCEP_CH_STRIDE   4
`define TCEP_CTRL_PRE    0
`define TCEP_CTRL_LOCK   1
`define TCEP_CTRL_IN     4
`define TCEP_LOCK_MIN    2'h2

`endif

/* hw/tcep_pkg.sv */
// Types of the channel enable block.
// Assumes tcep_defines.svh is on the include path.
`include "tcep_defines.svh"

package tcep_pkg;

   // ============================================================
   // Input edge code {comp polarity, polarity}
   typedef enum logic [1:0] {
      TCEP_EDGE_RISE = 2'h0,
      TCEP_EDGE_FALL = 2'h1,
      TCEP_EDGE_RSVD = 2'h2,
      TCEP_EDGE_BOTH = 2'h3
   } tcep_edge_t;

   // ============================================================
   // Captured AHB address phase
   typedef struct packed {
      logic       sel;
      logic       write;
      logic [7:0] addr;
   } tcep_dphase_t;

   // ============================================================
   // Whole state of the top module
   typedef struct packed {
      logic [15:0]  chen;
      logic [2:0]   cpol_shadow;
      logic [15:0]  cnt;
      logic [7:0]   ctrl;
      tcep_dphase_t dp;
      logic [31:0]  rdata;
      logic         ready;
      logic [3:0]   main_out;
      logic [2:0]   comp_out;
      logic [3:0]   cap_en;
      logic [3:0]   cap_strobe;
      logic [3:0]   ti_pol;
   } tcep_state_t;

endpackage

/* test/tcep_pins_model.sv */
// Far-side pin model: compare references, filtered inputs, commutation and count tick.
// Assumes the bench requests changes just after a rising edge of i_clk_sys.
`timescale 1ns/1ps

module tcep_pins_model (
   input  wire logic       i_clk_sys,
   input  wire logic [3:0] i_ref_req,
   input  wire logic [3:0] i_ti_req,
   input  wire logic       i_comm_req,
   input  wire logic       i_tick_req,
   output logic [3:0]      o_oc_ref,
   output logic [3:0]      o_ti_filt,
   output logic            o_commutation,
   output logic            o_count_tick
);
   // ============================================================
   // Pins settle one clock after each request
   initial begin
      o_oc_ref = 4'h0;
      o_ti_filt = 4'h0;
      o_commutation = 1'b0;
      o_count_tick = 1'b0;
   end

   always @(posedge i_clk_sys) begin
      o_oc_ref <= i_ref_req;
      o_ti_filt <= i_ti_req;
      o_commutation <= i_comm_req;
      o_count_tick <= i_tick_req;
   end
endmodule

/* test/tcep_bench.sv */
// Self-checking bench of the channel enable block, with an integer reference model.
// Assumes tcep_top, tcep_pins_model and a 100 MHz clock.
`timescale 1ns/1ps

module tcep_bench;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        clk_en = 1'b1;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [3:0]  ref_req = 4'h0;
   logic [3:0]  ti_req = 4'h0;
   logic        comm_req = 1'b0;
   logic        tick_req = 1'b0;
   logic [3:0]  oc_ref, ti_filt, main_out, cap_en, cap_stb, ti_pol;
   logic        comm, tick, hready, hresp;
   logic [2:0]  comp_out;
   logic [15:0] cnt_out;
   logic [31:0] hrdata, rd;
   logic [31:0] seed = 32'h795E;
   int          n_mismatch = 0;
   int          samples_checked = 0;
   int          chen, act_cp, a, b, p, q, inv, exp_s, im, en;
   int          sc[4];

   always #5 clk_sys = ~clk_sys;

   tcep_pins_model PINS (.i_clk_sys(clk_sys), .i_ref_req(ref_req), .i_ti_req(ti_req),
      .i_comm_req(comm_req), .i_tick_req(tick_req), .o_oc_ref(oc_ref), .o_ti_filt(ti_filt),
      .o_commutation(comm), .o_count_tick(tick));

   tcep_top DUT (.i_clk_sys(clk_sys), .i_rst(rst), .i_clk_en(clk_en), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
      .i_hwdata(hwdata), .i_hready(hready), .i_oc_ref(oc_ref), .i_ti_filt(ti_filt),
      .i_commutation(comm), .i_count_tick(tick), .o_hreadyout(hready), .o_hresp(hresp),
      .o_hrdata(hrdata), .o_main_out(main_out), .o_comp_out(comp_out),
      .o_capture_en(cap_en), .o_capture_strobe(cap_stb), .o_ti_pol(ti_pol),
      .o_counter_value(cnt_out));

   // ============================================================
   // Helpers
   function automatic logic [31:0] nxt();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   function automatic int ex_main(int c, int r);
      ex_main = 0;
      for (int i = 0; i < 4; i++) if (c[4*i]) ex_main |= (r[i] ^ c[4*i+1]) << i;
   endfunction

   function automatic int ex_comp(int c, int cp, int r);
      ex_comp = 0;
      for (int i = 0; i < 3; i++) if (c[4*i+2]) ex_comp |= (!r[i] ^ cp[4*i+3]) << i;
   endfunction

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic wait_rdy();
      int k = 0;
      @(negedge clk_sys);
      while (hready !== 1'b1 && k < 50) begin
         @(negedge clk_sys);
         k++;
      end
      if (k == 50) chk(0, 1, "hready");
      rd = hrdata;
      @(posedge clk_sys);
   endtask

   // ============================================================
   // AHB single word transfer
   task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, ad};
      hwrite <= wr;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      chk(hresp, 0, "hresp");
   endtask

   task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
      bus(1'b0, ad, 32'h0);
      chk(rd, exp, "read");
   endtask

   task automatic chk_out();
      chk(main_out, ex_main(chen, ref_req), "main");
      chk(comp_out, ex_comp(chen, act_cp, ref_req), "comp");
   endtask

   task automatic close_out();
      $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ============================================================
   // Watchdog
   initial begin
      step(20000);
      chk(0, 1, "watchdog");
      close_out();
   end

   // ============================================================
   // Tests
   initial begin
      step(20);
      rst <= 1'b0;
      step(1);
      rchk(8'h20, 0);
      rchk(8'h24, 0);
      rchk(8'h48, 0);
      rchk(8'h30, 0);
      $display("Test reset done");
      for (int i = 0; i < 8; i++) begin
         chen = nxt();
         ref_req <= 4'(nxt());
         bus(1'b1, 8'h20, chen);
         chen &= 'h3FFF;
         act_cp = chen;
         step(4);
         chk_out();
         rchk(8'h20, chen);
      end
      $display("Test outputs done");
      for (int lv = 1; lv < 4; lv++) begin
         bus(1'b1, 8'h48, lv << 1);
         a = nxt() & 'hFFFF;
         bus(1'b1, 8'h20, a);
         chen = (lv > 1) ? ((a & 'h3777) | (chen & 'h0888)) : (a & 'h3FFF);
         rchk(8'h20, chen);
      end
      bus(1'b1, 8'h48, 0);
      $display("Test lock done");
      bus(1'b1, 8'h20, 'h0777);
      bus(1'b1, 8'h48, 1);
      bus(1'b1, 8'h20, 'h0FFF);
      chen = 'h0FFF;
      act_cp = 'h0777;
      step(4);
      chk_out();
      rchk(8'h20, 'h0FFF);
      comm_req <= 1'b1;
      step(1);
      comm_req <= 1'b0;
      step(4);
      act_cp = chen;
      chk_out();
      $display("Test preload done");
      a = nxt() & 'hFFFF;
      bus(1'b1, 8'h24, a);
      tick_req <= 1'b1;
      step(5);
      tick_req <= 1'b0;
      step(3);
      chk(cnt_out, (a + 5) & 'hFFFF, "count");
      rchk(8'h24, (a + 5) & 'hFFFF);
      clk_en <= 1'b0;
      tick_req <= 1'b1;
      step(6);
      chk(cnt_out, (a + 5) & 'hFFFF, "freeze");
      tick_req <= 1'b0;
      step(3);
      clk_en <= 1'b1;
      step(3);
      chk(cnt_out, (a + 5) & 'hFFFF, "thaw");
      $display("Test counter done");
      bus(1'b1, 8'h48, 'hF0);
      for (int i = 0; i < 12; i++) begin
         chen = 0;
         for (int c = 0; c < 4; c++) begin
            a = nxt() % 3;
            chen |= (((a == 0) ? 0 : (a == 1) ? 'h2 : 'hA) | (nxt() & 1)) << 4*c;
         end
         bus(1'b1, 8'h20, chen);
         chen &= 'h3FFF;
         a = nxt() & 'hF;
         ti_req <= 4'(a);
         step(4);
         b = nxt() & 'hF;
         ti_req <= 4'(b);
         sc = '{0, 0, 0, 0};
         repeat (4) begin
            @(negedge clk_sys);
            for (int c = 0; c < 4; c++) sc[c] += cap_stb[c];
         end
         @(posedge clk_sys);
         im = 0;
         en = 0;
         for (int c = 0; c < 4; c++) begin
            inv = (chen >> (4*c+1) & 5) == 1;
            p = a[c] ^ inv;
            q = b[c] ^ inv;
            exp_s = (chen >> 4*c & 1) && (((chen >> (4*c+1) & 5) == 5) ? p != q : q && !p);
            chk(sc[c], exp_s, "strobe");
            im |= inv << c;
            en |= (chen >> 4*c & 1) << c;
         end
         chk(ti_pol, b ^ im, "tipol");
         chk(cap_en, en, "capen");
         chk(main_out, 0, "inmain");
      end
      $display("Test inputs done");
      close_out();
   end
endmodule
